// [ctio_top.v]
// Behaviour
// - Five independent 32-bit counter/timers per channel
// - Free-running astable for line rate or trigger
// - Astable period 1 us steps, 1 us up
// - Two exposure monostables, shared trigger, own lengths
// - Delay counter postpones trigger, us or lines
// - Delay non-retriggerable; triggers during delay discarded
// - Event counter counts lines, frames or microseconds
// - Counts within selected gate, restarts each gate
// - Running and previous-gate final count readable
// - Two 4-bit camera control output ports
// - Each control bit static or exposure pulse
// - Two isolated inputs and two isolated outputs
// - Isolated output: software, timer, or forwarded trigger
// - Two 2-bit control inputs, readable and trigger sources
// - Two 8-bit ports, whole-port direction by software
// - Trigger detector level or edge, selected input
// - Port latch enable: live when low, captured high
`timescale 1ns/1ps
`default_nettype none
`include "ctio_regs.vh"
module ctio_top #(
	parameter W  = 32,
	parameter PW = 8
) (
	input  wire          clk,
	input  wire          arst_n,
	input  wire [5:0]    reg_addr,
	input  wire [31:0]   reg_wdata,
	input  wire          reg_wr,
	input  wire          reg_rd,
	output reg  [31:0]   reg_rdata_q,
	input  wire          line_valid,
	input  wire          frame_valid,
	output wire [3:0]    cam_ctrl_a,
	output wire [3:0]    cam_ctrl_b,
	output wire          exposure_sync_out,
	output wire          pixel_reset_out,
	input  wire [1:0]    iso_in,
	output reg  [1:0]    iso_out_q,
	input  wire [1:0]    aux_in_a,
	input  wire [1:0]    aux_in_b,
	output wire          acq_trigger,
	input  wire [PW-1:0] port_a_in,
	output wire [PW-1:0] port_a_out,
	output wire [PW-1:0] port_a_oe_n,
	input  wire          port_a_len,
	input  wire [PW-1:0] port_b_in,
	output wire [PW-1:0] port_b_out,
	output wire [PW-1:0] port_b_oe_n,
	input  wire          port_b_len
);
	// Divider width is 8 bits; the integer count is cut to it on purpose
	localparam integer TICK_CYC_I = `CTIO_TICK_CYC;
	localparam [7:0]   TICK_CYC   = TICK_CYC_I[7:0];

	reg [1:0]    ctrl_q;
	reg [W-1:0]  period_q;
	reg [2:0]    mono_cfg_q;
	reg [W-1:0]  mono0_len_q;
	reg [W-1:0]  mono1_len_q;
	reg [1:0]    dly_cfg_q;
	reg [W-1:0]  dly_val_q;
	reg [3:0]    evt_cfg_q;
	reg [15:0]   cam_cfg_q;
	reg [7:0]    iso_cfg_q;
	reg [1:0]    pp_dir_q;
	reg [2*PW-1:0] pp_out_q;
	reg [4:0]    trg_cfg_q;

	// Shared microsecond tick; astable, monostables, delay and event counter can count on it
	reg [7:0] tdiv_q;
	wire      tick = (tdiv_q == TICK_CYC - 8'h01);
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			tdiv_q <= 8'h00;
		else if (tick)
			tdiv_q <= 8'h00;
		else
			tdiv_q <= tdiv_q + 8'h01;
	end

	// Edge history of the line and frame strobes
	reg lv_q, fv_q;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lv_q <= 1'b0;
			fv_q <= 1'b0;
		end else begin
			lv_q <= line_valid;
			fv_q <= frame_valid;
		end
	end
	wire lv_rise = line_valid & ~lv_q;
	wire lv_fall = ~line_valid & lv_q;
	wire fv_rise = frame_valid & ~fv_q;
	wire fv_fall = ~frame_valid & fv_q;

	// Astable: free-running, period in microsecond ticks
	reg [W-1:0] ast_cnt_q;
	reg         ast_pls_q;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ast_cnt_q <= {W{1'b0}};
			ast_pls_q <= 1'b0;
		end else begin
			ast_pls_q <= 1'b0;
			if (!ctrl_q[`CTIO_CTRL_AST_EN])
				ast_cnt_q <= {W{1'b0}};
			else if (tick) begin
				if (ast_cnt_q + {{(W-1){1'b0}}, 1'b1} >= period_q) begin
					ast_cnt_q <= {W{1'b0}};
					ast_pls_q <= 1'b1;
				end else
					ast_cnt_q <= ast_cnt_q + {{(W-1){1'b0}}, 1'b1};
			end
		end
	end

	// Trigger detector: selected isolated or control input
	wire [5:0] trg_src = {aux_in_b, aux_in_a, iso_in};
	wire [2:0] trg_sel = trg_cfg_q[4:2];
	wire       trg_raw = (trg_sel < 3'd6) ? trg_src[trg_sel] : 1'b0;
	wire       trg_lvl = trg_raw ^ trg_cfg_q[`CTIO_TRG_POL];
	reg        trg_lvl_q;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			trg_lvl_q <= 1'b0;
		else
			trg_lvl_q <= trg_lvl;
	end
	// Level mode repeats while held; with the delay stage on, one trigger passes per delay run
	wire ext_trg = trg_cfg_q[`CTIO_TRG_EDGE] ? (trg_lvl & ~trg_lvl_q)
	                                         : trg_lvl;

	// Delay counter, us or lines; busy ignores new triggers
	reg [W-1:0] dly_cnt_q;
	reg         dly_busy_q;
	reg         dly_done_q;
	wire        dly_step = dly_cfg_q[`CTIO_DLY_LINES] ? lv_rise : tick;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dly_cnt_q  <= {W{1'b0}};
			dly_busy_q <= 1'b0;
			dly_done_q <= 1'b0;
		end else begin
			dly_done_q <= 1'b0;
			if (!dly_busy_q) begin
				if (ext_trg && dly_cfg_q[`CTIO_DLY_EN]) begin
					if (dly_val_q == {W{1'b0}})
						dly_done_q <= 1'b1;
					else begin
						dly_busy_q <= 1'b1;
						dly_cnt_q  <= dly_val_q;
					end
				end
			end else if (dly_step) begin
				dly_cnt_q <= dly_cnt_q - {{(W-1){1'b0}}, 1'b1};
				if (dly_cnt_q == {{(W-1){1'b0}}, 1'b1}) begin
					dly_busy_q <= 1'b0;
					dly_done_q <= 1'b1;
				end
			end
		end
	end
	// Undelayed path when delay stage is off
	wire trg_evt = dly_cfg_q[`CTIO_DLY_EN] ? dly_done_q : ext_trg;
	assign acq_trigger = ctrl_q[`CTIO_CTRL_ACQ_EN] & trg_evt;

	// Shared monostable trigger select
	reg mono_fire;
	always @* begin
		case (mono_cfg_q[1:0])
			2'd0:    mono_fire = ast_pls_q;
			2'd1:    mono_fire = acq_trigger;
			2'd2:    mono_fire = lv_rise;
			default: mono_fire = fv_rise;
		endcase
	end
	wire mono_ok = mono_cfg_q[2] & mono_fire;

	// Two exposure monostables, shared fire, own lengths
	ctio_mono #(.W(W)) u_mono0 (
		.clk     (clk),
		.arst_n  (arst_n),
		.tick    (tick),
		.fire    (mono_ok),
		.len     (mono0_len_q),
		.pulse_q (exposure_sync_out)
	);
	ctio_mono #(.W(W)) u_mono1 (
		.clk     (clk),
		.arst_n  (arst_n),
		.tick    (tick),
		.fire    (mono_ok),
		.len     (mono1_len_q),
		.pulse_q (pixel_reset_out)
	);

	// Event counter: type and gate select
	reg evt_inc;
	always @* begin
		case (evt_cfg_q[1:0])
			2'd0:    evt_inc = lv_rise;
			2'd1:    evt_inc = fv_rise;
			2'd2:    evt_inc = tick;
			default: evt_inc = 1'b0;
		endcase
	end
	reg gate_lvl, gate_lvl_q;
	always @* begin
		case (evt_cfg_q[3:2])
			2'd0:    gate_lvl = line_valid;
			2'd1:    gate_lvl = frame_valid;
			2'd2:    gate_lvl = dly_busy_q | trg_lvl;
			default: gate_lvl = ctrl_q[`CTIO_CTRL_ACQ_EN];
		endcase
	end
	wire gate_start = gate_lvl & ~gate_lvl_q;
	wire gate_end   = ~gate_lvl & gate_lvl_q;
	reg [W-1:0] evt_cur_q;
	reg [W-1:0] evt_fin_q;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			gate_lvl_q <= 1'b0;
			evt_cur_q  <= {W{1'b0}};
			evt_fin_q  <= {W{1'b0}};
		end else begin
			gate_lvl_q <= gate_lvl;
			if (gate_start) // Restart per gate
				evt_cur_q <= {{(W-1){1'b0}}, evt_inc};
			else if (gate_lvl && evt_inc)
				evt_cur_q <= evt_cur_q + {{(W-1){1'b0}}, 1'b1};
			if (gate_end)
				evt_fin_q <= evt_cur_q;
		end
	end

	// Camera control bits: static or exposure pulse
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_cam
			assign cam_ctrl_a[gi] = cam_cfg_q[4+gi] ?
				exposure_sync_out : cam_cfg_q[gi];
			assign cam_ctrl_b[gi] = cam_cfg_q[12+gi] ?
				pixel_reset_out : cam_cfg_q[8+gi];
		end
	endgenerate

	// Isolated outputs, one of three sources each
	integer k;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			iso_out_q <= 2'b00;
		else
			for (k = 0; k < 2; k = k + 1)
				case (iso_cfg_q[4*k+2 +: 2])
					2'd0:    iso_out_q[k] <= iso_cfg_q[4*k];
					2'd1:    iso_out_q[k] <= exposure_sync_out;
					2'd2:    iso_out_q[k] <= acq_trigger;
					default: iso_out_q[k] <= 1'b0;
				endcase
	end

	// Parallel ports: whole-port direction; oe low drives
	assign port_a_out  = pp_out_q[PW-1:0];
	assign port_b_out  = pp_out_q[2*PW-1:PW];
	assign port_a_oe_n = {PW{~pp_dir_q[`CTIO_PP_DIR_A]}};
	assign port_b_oe_n = {PW{~pp_dir_q[`CTIO_PP_DIR_B]}};

	// Latch capture at rising latch enable
	reg [PW-1:0] lat_a_q, lat_b_q;
	reg          len_a_q, len_b_q;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lat_a_q <= {PW{1'b0}};
			lat_b_q <= {PW{1'b0}};
			len_a_q <= 1'b0;
			len_b_q <= 1'b0;
		end else begin
			len_a_q <= port_a_len;
			len_b_q <= port_b_len;
			if (port_a_len && !len_a_q)
				lat_a_q <= port_a_in;
			if (port_b_len && !len_b_q)
				lat_b_q <= port_b_in;
		end
	end
	// Rising-edge cycle still reads live pins; capture lands next
	wire [PW-1:0] rd_a = (port_a_len && len_a_q) ? lat_a_q : port_a_in;
	wire [PW-1:0] rd_b = (port_b_len && len_b_q) ? lat_b_q : port_b_in;

	// Register writes
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q      <= 2'b00;
			period_q    <= `CTIO_RST_PERIOD;
			mono_cfg_q  <= 3'b000;
			mono0_len_q <= `CTIO_RST_ZERO;
			mono1_len_q <= `CTIO_RST_ZERO;
			dly_cfg_q   <= 2'b00;
			dly_val_q   <= `CTIO_RST_ZERO;
			evt_cfg_q   <= 4'h0;
			cam_cfg_q   <= 16'h0000;
			iso_cfg_q   <= 8'h00;
			pp_dir_q    <= 2'b00;
			pp_out_q    <= {2*PW{1'b0}};
			trg_cfg_q   <= 5'h00;
		end else if (reg_wr) begin
			case (reg_addr)
				`CTIO_A_CTRL:      ctrl_q      <= reg_wdata[1:0];
				`CTIO_A_PERIOD:    period_q    <= reg_wdata[W-1:0];
				`CTIO_A_MONO_CFG:  mono_cfg_q  <= reg_wdata[2:0];
				`CTIO_A_MONO0_LEN: mono0_len_q <= reg_wdata[W-1:0];
				`CTIO_A_MONO1_LEN: mono1_len_q <= reg_wdata[W-1:0];
				`CTIO_A_DLY_CFG:   dly_cfg_q   <= reg_wdata[1:0];
				`CTIO_A_DLY_VAL:   dly_val_q   <= reg_wdata[W-1:0];
				`CTIO_A_EVT_CFG:   evt_cfg_q   <= reg_wdata[3:0];
				`CTIO_A_CAM_CFG:   cam_cfg_q   <= reg_wdata[15:0];
				`CTIO_A_ISO_CFG:   iso_cfg_q   <= reg_wdata[7:0];
				`CTIO_A_PP_CTRL:   pp_dir_q    <= reg_wdata[1:0];
				`CTIO_A_PP_DATA:   pp_out_q    <= reg_wdata[2*PW-1:0];
				`CTIO_A_TRG_CFG:   trg_cfg_q   <= reg_wdata[4:0];
				default: ;
			endcase
		end
	end

	// Read data registered, valid the cycle after the strobe
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			reg_rdata_q <= 32'h00000000;
		else if (!reg_rd)
			reg_rdata_q <= 32'h00000000;
		else
			case (reg_addr)
				`CTIO_A_CTRL:      reg_rdata_q <= {30'h0, ctrl_q};
				`CTIO_A_PERIOD:    reg_rdata_q <= period_q;
				`CTIO_A_MONO_CFG:  reg_rdata_q <= {29'h0, mono_cfg_q};
				`CTIO_A_MONO0_LEN: reg_rdata_q <= mono0_len_q;
				`CTIO_A_MONO1_LEN: reg_rdata_q <= mono1_len_q;
				`CTIO_A_DLY_CFG:
					reg_rdata_q <= {29'h0, dly_busy_q, dly_cfg_q};
				`CTIO_A_DLY_VAL:   reg_rdata_q <= dly_val_q;
				`CTIO_A_EVT_CFG:   reg_rdata_q <= {28'h0, evt_cfg_q};
				`CTIO_A_EVT_CUR:   reg_rdata_q <= evt_cur_q;
				`CTIO_A_EVT_FIN:   reg_rdata_q <= evt_fin_q;
				`CTIO_A_CAM_CFG:   reg_rdata_q <= {16'h0, cam_cfg_q};
				`CTIO_A_ISO_CFG:   reg_rdata_q <= {24'h0, iso_cfg_q};
				`CTIO_A_IN_STAT:   // Input status
					reg_rdata_q <= {24'h0, iso_out_q, aux_in_b,
					                aux_in_a, iso_in};
				`CTIO_A_PP_CTRL:   reg_rdata_q <= {30'h0, pp_dir_q};
				`CTIO_A_PP_DATA:
					reg_rdata_q <= {{(32-2*PW){1'b0}}, rd_b, rd_a};
				`CTIO_A_TRG_CFG:   reg_rdata_q <= {27'h0, trg_cfg_q};
				default:           reg_rdata_q <= 32'h00000000;
			endcase
	end
endmodule
`default_nettype wire

// [ctio_regs.vh]
`ifndef CTIO_REGS_VH
`define CTIO_REGS_VH
// Register indices on the plain register port (word addresses)
`define CTIO_A_CTRL      6'h00
`define CTIO_A_PERIOD    6'h01
`define CTIO_A_MONO_CFG  6'h02
`define CTIO_A_MONO0_LEN 6'h03
`define CTIO_A_MONO1_LEN 6'h04
`define CTIO_A_DLY_CFG   6'h05
`define CTIO_A_DLY_VAL   6'h06
`define CTIO_A_EVT_CFG   6'h07
`define CTIO_A_EVT_CUR   6'h08
`define CTIO_A_EVT_FIN   6'h09
`define CTIO_A_CAM_CFG   6'h0A
`define CTIO_A_ISO_CFG   6'h0B
`define CTIO_A_IN_STAT   6'h0C
`define CTIO_A_PP_CTRL   6'h0D
`define CTIO_A_PP_DATA   6'h0E
`define CTIO_A_TRG_CFG   6'h0F
// Field positions
`define CTIO_CTRL_AST_EN   0
`define CTIO_CTRL_ACQ_EN   1
`define CTIO_DLY_LINES     0
`define CTIO_DLY_EN        1
`define CTIO_TRG_EDGE      0
`define CTIO_TRG_POL       1
`define CTIO_TRG_SEL_LO    2
`define CTIO_PP_DIR_A      0
`define CTIO_PP_DIR_B      1
// Reset values
`define CTIO_RST_PERIOD    32'h000003E8
`define CTIO_RST_ZERO      32'h00000000
// Timebase
`define CTIO_CLK_HZ        20000000
`define CTIO_TICK_NS       1000
`define CTIO_CLK_NS        50
`define CTIO_TICK_CYC      (`CTIO_TICK_NS / `CTIO_CLK_NS)
`endif

// [ctio_mono.v]
`timescale 1ns/1ps
`default_nettype none
// Monostable: fires on a trigger pulse, high for len microsecond ticks
module ctio_mono #(
	parameter W = 32
) (
	input  wire         clk,
	input  wire         arst_n,
	input  wire         tick,
	input  wire         fire,
	input  wire [W-1:0] len,
	output reg          pulse_q
);
	reg [W-1:0] cnt_q;

	// Retriggerable: a new fire restarts the pulse length
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q   <= {W{1'b0}};
			pulse_q <= 1'b0;
		end else if (fire && len != {W{1'b0}}) begin
			cnt_q   <= len;
			pulse_q <= 1'b1;
		end else if (tick && pulse_q) begin
			cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
			if (cnt_q == {{(W-1){1'b0}}, 1'b1})
				pulse_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [ctio_sva.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ctio_regs.vh"
// Read port, parallel port and camera mux checks
module ctio_sva #(
	parameter PW = 8
) (
	input wire logic          clk,
	input wire logic          arst_n,
	input wire logic [5:0]    reg_addr,
	input wire logic [31:0]   reg_wdata,
	input wire logic          reg_wr,
	input wire logic          reg_rd,
	input wire logic [31:0]   reg_rdata_q,
	input wire logic [3:0]    cam_ctrl_a,
	input wire logic [3:0]    cam_ctrl_b,
	input wire logic          exposure_sync_out,
	input wire logic          pixel_reset_out,
	input wire logic [PW-1:0] port_a_out,
	input wire logic [PW-1:0] port_a_oe_n,
	input wire logic [PW-1:0] port_b_out,
	input wire logic [PW-1:0] port_b_oe_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic [15:0] cam_q;
	logic [15:0] data_q;
	logic [1:0]  dir_q;
	// Shadow copies of mux registers, so outputs can be predicted
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cam_q  <= 16'h0000;
			data_q <= 16'h0000;
			dir_q  <= 2'h0;
		end else if (reg_wr) begin
			if (reg_addr == `CTIO_A_CAM_CFG) cam_q <= reg_wdata[15:0];
			if (reg_addr == `CTIO_A_PP_DATA) data_q <= reg_wdata[15:0];
			if (reg_addr == `CTIO_A_PP_CTRL) dir_q <= reg_wdata[1:0];
		end
	end
	sequence s_bad_rd;
		reg_rd && reg_addr > 6'h0F;
	endsequence
	chk_rd_quiet: assert property (
		!$past(reg_rd) |-> reg_rdata_q == 32'h00000000)
		else $error("read data not zero outside answer cycle");
	chk_rd_unmapped: assert property (
		s_bad_rd |=> reg_rdata_q == 32'h00000000)
		else $error("unmapped read not zero");
	chk_oe_a_dir: assert property (
		port_a_oe_n == {PW{~dir_q[0]}}) else $error("port a direction");
	chk_oe_b_dir: assert property (
		port_b_oe_n == {PW{~dir_q[1]}}) else $error("port b direction");
	chk_out_a_data: assert property (
		port_a_out == data_q[PW-1:0]) else $error("port a data");
	chk_out_b_data: assert property (
		port_b_out == data_q[PW +: PW]) else $error("port b data");
	chk_cam_a_mux: assert property (
		cam_ctrl_a == ((cam_q[7:4] & {4{exposure_sync_out}}) |
		(~cam_q[7:4] & cam_q[3:0]))) else $error("camera port a mux");
	chk_cam_b_mux: assert property (
		cam_ctrl_b == ((cam_q[15:12] & {4{pixel_reset_out}}) |
		(~cam_q[15:12] & cam_q[11:8]))) else $error("camera port b mux");
endmodule
bind ctio_top ctio_sva #(.PW(PW)) i_ctio_sva (.clk(clk), .arst_n(arst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .cam_ctrl_a(cam_ctrl_a),
	.cam_ctrl_b(cam_ctrl_b), .exposure_sync_out(exposure_sync_out),
	.pixel_reset_out(pixel_reset_out), .port_a_out(port_a_out),
	.port_a_oe_n(port_a_oe_n), .port_b_out(port_b_out),
	.port_b_oe_n(port_b_oe_n));
`default_nettype wire

// [ctio_cam_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Camera timing source: LINES lines per frame, one gap line after
module ctio_cam_model #(
	parameter LINES = 3,
	parameter LHI   = 30,
	parameter LLO   = 10
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic run,
	output var logic line_valid,
	output var logic frame_valid
);
	int cnt;
	int ln;
	// A frame in progress always completes, even if run drops
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt         <= 0;
			ln          <= 0;
			line_valid  <= 1'b0;
			frame_valid <= 1'b0;
		end else if (run || frame_valid) begin
			cnt <= (cnt == LHI + LLO - 1) ? 0 : cnt + 1;
			if (cnt == LHI + LLO - 1)
				ln <= (ln == LINES) ? 0 : ln + 1;
			frame_valid <= (ln < LINES);
			line_valid  <= (ln < LINES) && (cnt >= LLO);
		end
	end
endmodule
`default_nettype wire

// [ctio_top_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ctio_regs.vh"
module ctio_top_tb_top;
	logic        clk, arst_n, reg_wr, reg_rd, run, port_a_len, port_b_len;
	logic        line_valid, frame_valid, acq_trigger;
	logic        exposure_sync_out, pixel_reset_out;
	logic [5:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata_q, got;
	logic [3:0]  cam_ctrl_a, cam_ctrl_b;
	logic [1:0]  iso_in, iso_out_q, aux_in_a, aux_in_b;
	logic [7:0]  port_a_in, port_a_out, port_a_oe_n;
	logic [7:0]  port_b_in, port_b_out, port_b_oe_n;
	int          bad_count = 0, n_tests = 0, cyc = 0, t0, t1, n;
	ctio_top i_ctio_top (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q), .line_valid(line_valid),
		.frame_valid(frame_valid), .cam_ctrl_a(cam_ctrl_a),
		.cam_ctrl_b(cam_ctrl_b), .exposure_sync_out(exposure_sync_out),
		.pixel_reset_out(pixel_reset_out), .iso_in(iso_in),
		.iso_out_q(iso_out_q), .aux_in_a(aux_in_a), .aux_in_b(aux_in_b),
		.acq_trigger(acq_trigger), .port_a_in(port_a_in),
		.port_a_out(port_a_out), .port_a_oe_n(port_a_oe_n),
		.port_a_len(port_a_len), .port_b_in(port_b_in),
		.port_b_out(port_b_out), .port_b_oe_n(port_b_oe_n),
		.port_b_len(port_b_len));
	ctio_cam_model i_ctio_cam_model (.clk(clk), .arst_n(arst_n), .run(run),
		.line_valid(line_valid), .frame_valid(frame_valid));
	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Hang guard, well above the expected run length
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			print_verdict();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		// Let the write settle before anyone looks at outputs
		#1;
	endtask
	// Data stands only in the cycle after the strobe
	task automatic rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata_q;
	endtask
	task automatic step;
		@(posedge clk);
		#1;
	endtask
	task print_verdict;
		if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Main sequence
	initial begin
		{arst_n, reg_wr, reg_rd, run, port_a_len, port_b_len} = 6'h00;
		{reg_addr, reg_wdata, iso_in, port_a_in} = 0;
		aux_in_a = 2'b10;
		aux_in_b = 2'b01;
		port_b_in = 8'h3C;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		rd(`CTIO_A_PERIOD, got); chk(got, `CTIO_RST_PERIOD);
		wr(6'h2A, 32'hFFFFFFFF);
		rd(6'h2A, got); chk(got, 32'h00000000);
		wr(`CTIO_A_ISO_CFG, 32'h00000011);
		rd(`CTIO_A_IN_STAT, got); chk(got, 32'h000000D8);
		// Port A drives, port B reads live then latched
		wr(`CTIO_A_PP_CTRL, 32'h00000001);
		wr(`CTIO_A_PP_DATA, 32'h0000A55A);
		chk({port_b_oe_n, port_a_oe_n}, 32'h0000FF00);
		rd(`CTIO_A_PP_DATA, got); chk(got[15:8], 32'h3C);
		@(posedge clk) port_b_len <= 1'b1;
		@(posedge clk) port_b_in <= 8'hC3;
		rd(`CTIO_A_PP_DATA, got); chk(got[15:8], 32'h3C);
		@(posedge clk) port_b_len <= 1'b0;
		rd(`CTIO_A_PP_DATA, got); chk(got[15:8], 32'hC3);
		wr(`CTIO_A_CAM_CFG, 32'h00000A05);
		chk({cam_ctrl_b, cam_ctrl_a}, 32'hA5);
		// Astable fires both monostables, outputs follow the pulses
		wr(`CTIO_A_CAM_CFG, 32'h0000F0F0);
		wr(`CTIO_A_PERIOD, 32'h5);
		wr(`CTIO_A_MONO0_LEN, 32'h2);
		wr(`CTIO_A_MONO1_LEN, 32'h3);
		wr(`CTIO_A_MONO_CFG, 32'h4);
		wr(`CTIO_A_CTRL, 32'h1);
		for (n = 0; !exposure_sync_out && n < 1000; n++) step();
		chk(pixel_reset_out, 1);
		t0 = cyc;
		for (n = 0; exposure_sync_out && n < 200; n++) step();
		chk(n > 20 && n <= 40, 1);
		while (!exposure_sync_out && cyc < t0 + 300) step();
		chk(cyc - t0, 100);
		wr(`CTIO_A_CTRL, 32'h0);
		// Lines counted over one frame gate
		wr(`CTIO_A_EVT_CFG, 32'h4);
		run <= 1'b1;
		while (!frame_valid) step();
		while (frame_valid) step();
		while (!frame_valid) step();
		run <= 1'b0;
		rd(`CTIO_A_EVT_FIN, got); chk(got, 32'h3);
		// New frame gate has just opened, no line yet
		rd(`CTIO_A_EVT_CUR, got); chk(got, 32'h0);
		// Second trigger inside the delay is dropped
		wr(`CTIO_A_TRG_CFG, 32'h1);
		wr(`CTIO_A_DLY_VAL, 32'h3);
		wr(`CTIO_A_DLY_CFG, 32'h2);
		wr(`CTIO_A_CTRL, 32'h2);
		t0 = cyc;
		n = 0;
		for (int i = 0; i < 200; i++) begin
			@(posedge clk);
			iso_in <= (i < 2 || i == 20 || i == 21) ? 2'b01 : 2'b00;
			#1;
			if (acq_trigger) n++;
			if (acq_trigger && n == 1) t1 = cyc;
		end
		chk(n, 1);
		chk(t1 - t0 > 40, 1);
		print_verdict();
	end
endmodule
`default_nettype wire
